// File: logic/jrm_pkg.sv
// Package with register map, command codes and timing constants of the request monitor
package jrm_pkg;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_ARG    = 8'h08;
  localparam logic [7:0] OFS_ID     = 8'h0c;
  localparam logic [7:0] OFS_RATE   = 8'h10;
  localparam logic [7:0] OFS_STORED = 8'h14;
  localparam logic [7:0] OFS_TMO    = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_RXHDR  = 8'h20;

  // ***************************************************************
  // Control register fields
  // ***************************************************************
  localparam int CTRL_HDR_SHOW = 0;
  localparam int CTRL_HDR_FMT  = 1;
  localparam int CTRL_SWAP     = 2;
  localparam int CTRL_SILENT   = 3;
  localparam int CTRL_X5       = 4;

  // ***************************************************************
  // Command codes, written to the low byte of the command register
  // ***************************************************************
  localparam logic [7:0] CMD_STOP        = 8'h00;
  localparam logic [7:0] CMD_TESTER_ADDR = 8'h01;
  localparam logic [7:0] CMD_PRIORITY    = 8'h02;
  localparam logic [7:0] CMD_HEADER3     = 8'h03;
  localparam logic [7:0] CMD_HEADER4     = 8'h04;
  localparam logic [7:0] CMD_PROTOCOL    = 8'h05;
  localparam logic [7:0] CMD_OPTS_DIV    = 8'h06;
  localparam logic [7:0] CMD_STORE_RATE  = 8'h07;
  localparam logic [7:0] CMD_TMO_X5      = 8'h08;
  localparam logic [7:0] CMD_TMO_X1      = 8'h09;
  localparam logic [7:0] CMD_DM1         = 8'h0a;
  localparam logic [7:0] CMD_SILENT_OFF  = 8'h0b;
  localparam logic [7:0] CMD_GROUP_MON   = 8'h0c;
  localparam logic [7:0] CMD_HDR_ON      = 8'h0d;
  localparam logic [7:0] CMD_HDR_FMT_OFF = 8'h0e;
  localparam logic [7:0] CMD_SWAP_OFF    = 8'h0f;
  localparam logic [7:0] CMD_REQUEST     = 8'h10;
  localparam logic [7:0] CMD_SOFT_RESET  = 8'h11;

  // ***************************************************************
  // Identifier layout and values after reset
  // ***************************************************************
  localparam int          ID_W          = 29;
  localparam int          PF_HI         = 23;
  localparam logic [3:0]  PF_BCAST_NIB  = 4'hf;
  localparam logic [7:0]  GLOBAL_ADDR   = 8'hff;
  localparam logic [7:0]  TESTER_ADDR   = 8'hf9;
  localparam logic [28:0] ID_RST        = 29'h18eafff9;
  localparam logic [7:0]  DM1_PF        = 8'hfe;
  localparam logic [7:0]  DM1_PS        = 8'hca;
  localparam logic [7:0]  J_OPTIONS     = 8'h42;
  localparam logic [7:0]  PROTO_A       = 8'h0a;
  localparam logic [7:0]  RATE_BASE_K   = 8'd250;
  localparam logic [7:0]  DIV_BASE_K    = 8'd250;
  localparam logic [7:0]  DIV_250K      = 8'h02;
  localparam logic [7:0]  STORED_OPT_RST = 8'h42;
  localparam logic [7:0]  STORED_DIV_RST = 8'h01;
  localparam logic [4:0]  CTRL_RST      = 5'b01110;
  localparam logic [2:0]  TMO_MULT      = 3'd5;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int          CLK_NS        = 10;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = MS_NS / CLK_NS;
  localparam logic [7:0]  TMO_MS_RST    = 8'd100;

  typedef enum logic [1:0] {JRM_IDLE, JRM_SEND, JRM_WAIT, JRM_MON} jrm_state_t;

endpackage

// File: logic/jrm_id_decode.sv
// Identifier classifier and header display formatter
`timescale 1ns/1ps

module jrm_id_decode
  import jrm_pkg::*;
(
  // Identifier in
  input  wire logic [28:0] id,
  input  wire logic        hdr_fmt,
  // Classification
  output logic             broadcast,
  output logic             global_dst,
  output logic [17:0]      group,
  // Display word
  output logic [31:0]      disp
);

  logic [7:0] pf;
  logic [7:0] ps;

  assign pf = id[PF_HI -: 8];
  assign ps = id[PF_HI-8 -: 8];

  always_comb begin
    broadcast  = (pf[7:4] == PF_BCAST_NIB);
    global_dst = !broadcast && (ps == GLOBAL_ADDR);
    group      = broadcast ? id[25:8] : {id[25:16], 8'h00};
    if (hdr_fmt) begin
      // Priority digit, then one digit for both page bits
      disp = {1'b0, id[28:26], 2'b00, id[25:24], id[23:0]};
    end else begin
      disp = {3'b000, id[28:0]};
    end
  end

endmodule

// File: logic/jrm_monitor.sv
// Request monitor: command register file, request sender and group monitor
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Functional notes
// - format upper digit F means broadcast
// - addressed frame to FF is global
// - fixed source F9, changed by command
// - header loadable in one or two steps
// - drop three top bits of written values
// - protocol A gives 250 kbps directly
// - other protocols use options 42 and divisor
// - command rate lost on soft reset, stored kept
// - timeout times five, then back to one
// - trouble-code monitor runs until host character
// - silent by default, ack when turned off
// - unacknowledged frame printed with error marker while silent
// - group of six digits or four plus 00
// - trailing count limits monitored messages
// - headers hidden until display turned on
// - formatted header: priority, page digit, bytes
// - unformatted header: five-bit first byte
// - group number line sends a request
// - default request identifier 6 EA FF F9
// - request group bytes sent reversed unless disabled
module jrm_monitor
  import jrm_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
)(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Request transmit
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  output logic [jrm_pkg::ID_W-1:0] tx_id,
  output logic [23:0]              tx_data,
  // Received frames
  input  wire logic                rx_valid,
  input  wire logic [jrm_pkg::ID_W-1:0] rx_id,
  input  wire logic                rx_acked,
  input  wire logic                rx_msg_done,
  // CAN controller setup
  output logic                     ack_enable,
  output logic [7:0]               can_options,
  output logic [7:0]               can_divisor,
  // Print stream
  output logic                     out_valid,
  output logic [31:0]              out_header,
  output logic                     out_show_header,
  output logic                     out_rx_error,
  output logic                     out_prompt
);

  // ***************************************************************
  // Storage
  // ***************************************************************
  jrm_state_t  state;
  logic [4:0]  ctrl;
  logic [31:0] arg;
  logic [28:0] id_reg;
  logic [7:0]  pb_opt;
  logic [7:0]  pb_div;
  logic [7:0]  st_opt;
  logic [7:0]  st_div;
  logic [7:0]  proto;
  logic [7:0]  tmo_ms;
  logic [23:0] grp;
  logic [3:0]  mon_left;
  logic        no_data;
  logic        got_reply;
  logic [31:0] ms_cnt;
  logic [10:0] ms_left;
  logic        rx_broadcast;
  logic        rx_global;
  logic [17:0] rx_group;
  logic [31:0] rx_disp;
  logic        wr;
  logic        rd_setup;
  logic        cmd_wr;
  logic [7:0]  cmd;
  logic        mapped;
  logic        grp_hit;
  logic        ms_tick;

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= OFS_RXHDR);
  endfunction

  assign mapped   = is_mapped(paddr);
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !mapped;
  assign wr       = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign cmd_wr   = wr && (paddr == OFS_CMD);
  assign cmd      = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      unique case (paddr)
        OFS_CTRL:   prdata <= {27'h0, ctrl};
        OFS_ARG:    prdata <= arg;
        OFS_ID:     prdata <= {3'b000, id_reg};
        OFS_RATE:   prdata <= {8'h00, proto, can_options, can_divisor};
        OFS_STORED: prdata <= {16'h0, st_opt, st_div};
        OFS_TMO:    prdata <= {24'h0, tmo_ms};
        OFS_STATUS: prdata <= {18'h0, mon_left, got_reply, no_data, 6'h0, state};
        OFS_RXHDR:  prdata <= out_header;
        default:    prdata <= 32'h0;
      endcase
    end
  end

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arg <= 32'h0;
    end else if (wr && paddr == OFS_ARG) begin
      arg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
    end else if (cmd_wr && cmd == CMD_SOFT_RESET) begin
      ctrl <= CTRL_RST;
    end else if (wr && paddr == OFS_CTRL) begin
      ctrl <= pwdata[4:0];
    end else if (cmd_wr) begin
      unique case (cmd)
        CMD_HDR_ON:      ctrl[CTRL_HDR_SHOW] <= 1'b1;
        CMD_HDR_FMT_OFF: ctrl[CTRL_HDR_FMT]  <= 1'b0;
        CMD_SWAP_OFF:    ctrl[CTRL_SWAP]     <= 1'b0;
        CMD_SILENT_OFF:  ctrl[CTRL_SILENT]   <= 1'b0;
        CMD_TMO_X5:      ctrl[CTRL_X5]       <= 1'b1;
        CMD_TMO_X1:      ctrl[CTRL_X5]       <= 1'b0;
        default:         ;
      endcase
    end
  end

  // Identifier of outgoing requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_reg <= ID_RST;
    end else if (cmd_wr) begin
      unique case (cmd)
        CMD_TESTER_ADDR: id_reg[7:0]   <= arg[7:0];
        CMD_PRIORITY:    id_reg[28:24] <= arg[4:0];
        CMD_HEADER3:     id_reg[23:0]  <= arg[23:0];
        CMD_HEADER4:     id_reg        <= arg[28:0];
        CMD_SOFT_RESET:  id_reg        <= ID_RST;
        default:         ;
      endcase
    end
  end

  // Rate set by command is volatile; stored copy survives soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_opt <= STORED_OPT_RST;
      pb_div <= STORED_DIV_RST;
      st_opt <= STORED_OPT_RST;
      st_div <= STORED_DIV_RST;
      proto  <= PROTO_A;
      tmo_ms <= TMO_MS_RST;
    end else begin
      if (cmd_wr && cmd == CMD_OPTS_DIV) begin
        pb_opt <= arg[15:8];
        pb_div <= arg[7:0];
      end else if (cmd_wr && cmd == CMD_SOFT_RESET) begin
        pb_opt <= st_opt;
        pb_div <= st_div;
      end
      if (cmd_wr && cmd == CMD_STORE_RATE) begin
        st_opt <= arg[15:8];
        st_div <= arg[7:0];
      end
      if (cmd_wr && cmd == CMD_PROTOCOL) begin
        proto <= arg[7:0];
      end
      if (wr && paddr == OFS_TMO) begin
        tmo_ms <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_options <= J_OPTIONS;
      can_divisor <= DIV_250K;
    end else if (proto == PROTO_A) begin
      can_options <= J_OPTIONS;
      can_divisor <= DIV_250K;
    end else begin
      can_options <= pb_opt;
      can_divisor <= pb_div;
    end
  end

  assign ack_enable = !ctrl[CTRL_SILENT];

  // ***************************************************************
  // Received frame classification
  // ***************************************************************
  jrm_id_decode u_dec (
    .id        (rx_id),
    .hdr_fmt   (ctrl[CTRL_HDR_FMT]),
    .broadcast (rx_broadcast),
    .global_dst(rx_global),
    .group     (rx_group),
    .disp      (rx_disp)
  );

  assign grp_hit = rx_valid && (rx_group == grp[17:0]);

  // ***************************************************************
  // Reply timeout, counted in milliseconds
  // ***************************************************************
  assign ms_tick = (ms_cnt == 32'(MS_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 32'h0;
    end else if (state != JRM_WAIT || rx_valid || ms_tick) begin
      ms_cnt <= 32'h0;
    end else begin
      ms_cnt <= ms_cnt + 32'h1;
    end
  end

  // ***************************************************************
  // Command sequencer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= JRM_IDLE;
      grp       <= 24'h0;
      mon_left  <= 4'h0;
      no_data   <= 1'b0;
      got_reply <= 1'b0;
      ms_left   <= 11'h0;
    end else begin
      unique case (state)
        JRM_IDLE: begin
          if (cmd_wr && cmd == CMD_DM1) begin
            grp      <= {8'h00, DM1_PF, DM1_PS};
            mon_left <= 4'h0;
            state    <= JRM_MON;
          end else if (cmd_wr && cmd == CMD_GROUP_MON) begin
            // Four-digit group gets 00 as upper byte
            grp      <= arg[28] ? arg[23:0] : {8'h00, arg[15:0]};
            mon_left <= arg[27:24];
            state    <= JRM_MON;
          end else if (cmd_wr && cmd == CMD_REQUEST) begin
            grp       <= arg[23:0];
            no_data   <= 1'b0;
            got_reply <= 1'b0;
            state     <= JRM_SEND;
          end
        end
        JRM_SEND: begin
          if (tx_ready) begin
            ms_left <= ctrl[CTRL_X5] ? 11'(tmo_ms * TMO_MULT) : {3'b000, tmo_ms};
            state   <= JRM_WAIT;
          end
        end
        JRM_WAIT: begin
          if (rx_valid) begin
            got_reply <= 1'b1;
            ms_left   <= ctrl[CTRL_X5] ? 11'(tmo_ms * TMO_MULT) : {3'b000, tmo_ms};
          end else if (ms_tick) begin
            if (ms_left <= 11'h1) begin
              no_data <= !got_reply;
              state   <= JRM_IDLE;
            end else begin
              ms_left <= ms_left - 11'h1;
            end
          end
        end
        JRM_MON: begin
          if (cmd_wr) begin
            state <= JRM_IDLE;
          end else if (grp_hit && rx_msg_done && mon_left != 4'h0) begin
            mon_left <= mon_left - 4'h1;
            if (mon_left == 4'h1) begin
              state <= JRM_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // Request output, group bytes reversed unless swapping is off
  // ***************************************************************
  assign tx_valid = (state == JRM_SEND);
  assign tx_id    = id_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data <= 24'h0;
    end else if (state == JRM_IDLE) begin
      tx_data <= ctrl[CTRL_SWAP] ? {arg[7:0], arg[15:8], arg[23:16]} : arg[23:0];
    end
  end

  // ***************************************************************
  // Print stream
  // ***************************************************************
  function automatic logic next_idle_flag();
    next_idle_flag = (state == JRM_MON && (cmd_wr ||
                      (grp_hit && rx_msg_done && mon_left == 4'h1))) ||
                     (state == JRM_WAIT && !rx_valid && ms_tick && ms_left <= 11'h1);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid       <= 1'b0;
      out_header      <= 32'h0;
      out_show_header <= 1'b0;
      out_rx_error    <= 1'b0;
      out_prompt      <= 1'b0;
    end else begin
      out_valid       <= rx_valid && (state == JRM_WAIT || (state == JRM_MON && grp_hit));
      if (rx_valid) begin
        out_header    <= rx_disp;
      end
      out_show_header <= ctrl[CTRL_HDR_SHOW];
      out_rx_error    <= rx_valid && !rx_acked && ctrl[CTRL_SILENT];
      out_prompt      <= (state != JRM_IDLE) && (next_idle_flag());
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_rst_id;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> id_reg == ID_RST;
  endproperty
  a_rst_id: assert property (p_rst_id) else $error("request id not default");

  property p_priority;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && cmd == CMD_PRIORITY |=> id_reg[28:24] == $past(arg[4:0]) &&
        id_reg[23:0] == $past(id_reg[23:0]);
  endproperty
  a_priority: assert property (p_priority) else $error("priority load wrong");

  property p_header3;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && cmd == CMD_HEADER3 |=> id_reg[28:24] == $past(id_reg[28:24]);
  endproperty
  a_header3: assert property (p_header3) else $error("priority changed");

  property p_rate_a;
    @(posedge pclk) disable iff (!presetn)
      proto == PROTO_A |=> can_divisor == DIV_250K && can_options == J_OPTIONS;
  endproperty
  a_rate_a: assert property (p_rate_a) else $error("protocol A rate wrong");

  property p_x5;
    @(posedge pclk) disable iff (!presetn)
      state == JRM_SEND && tx_ready && ctrl[CTRL_X5] |=>
        ms_left == 11'(tmo_ms * TMO_MULT);
  endproperty
  a_x5: assert property (p_x5) else $error("timeout not stretched");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      state == JRM_MON && cmd_wr |=> state == JRM_IDLE && out_prompt;
  endproperty
  a_stop: assert property (p_stop) else $error("monitor not stopped");

  property p_silent;
    @(posedge pclk) disable iff (!presetn)
      rx_valid && !rx_acked && !ack_enable |=> out_rx_error;
  endproperty
  a_silent: assert property (p_silent) else $error("error marker missing");

  property p_swap;
    @(posedge pclk) disable iff (!presetn)
      tx_valid && ctrl[CTRL_SWAP] && $past(state) == JRM_IDLE |->
        tx_data == {$past(arg[7:0]), $past(arg[15:8]), $past(arg[23:16])};
  endproperty
  a_swap: assert property (p_swap) else $error("group bytes not reversed");

  property p_class;
    @(posedge pclk) disable iff (!presetn)
      rx_valid && rx_id[15:8] == GLOBAL_ADDR && rx_id[23:20] != PF_BCAST_NIB |->
        rx_global && !rx_broadcast;
  endproperty
  a_class: assert property (p_class) else $error("global frame misclassified");

endmodule

// File: sim/jrm_can_model.sv
// CAN controller model facing the request monitor
`timescale 1ns/1ps

// ***************************************************************
// CAN controller model
// ***************************************************************
module jrm_can_model
  import jrm_pkg::*;
#(
  parameter int GAP = 500
)(
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Request side
  input  wire logic                     tx_valid,
  input  wire logic [jrm_pkg::ID_W-1:0] tx_id,
  input  wire logic [23:0]              tx_data,
  output logic                          tx_ready = 1'b0,
  // Received frames
  output logic                          rx_valid = 1'b0,
  output logic [jrm_pkg::ID_W-1:0]      rx_id = '0,
  output logic                          rx_acked = 1'b0,
  output logic                          rx_msg_done = 1'b0
);
  import jrm_pkg::*;

  int              stall = 3;
  int              wait_cnt = 0;
  logic [ID_W-1:0] got_id = '0;
  logic [23:0]     got_data = '0;

  // Takes a request after a settable number of stall cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_valid && tx_ready) begin
      got_id   <= tx_id;
      got_data <= tx_data;
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_valid) begin
      wait_cnt <= wait_cnt + 1;
      tx_ready <= (wait_cnt >= stall);
    end
  end

  // Idle id and ack lines show the inverse of the last frame, never a stale copy
  task automatic send_frame(input logic [ID_W-1:0] id, input logic ack, input logic done);
    repeat (GAP) @(posedge pclk);
    rx_valid    <= 1'b1;
    rx_id       <= id;
    rx_acked    <= ack;
    rx_msg_done <= done;
    @(posedge pclk);
    rx_valid    <= 1'b0;
    rx_msg_done <= 1'b0;
    rx_id       <= ~id;
    rx_acked    <= ~ack;
  endtask
endmodule

// File: sim/tb_jrm_monitor.sv
// Testbench of the request monitor
`timescale 1ns/1ps

// ***************************************************************
// Bench
// ***************************************************************
module tb_jrm_monitor;
  import jrm_pkg::*;

  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = '0;
  logic [31:0]     pwdata = '0;
  logic [31:0]     prdata, rd_data, out_header;
  logic            pready, pslverr, rd_err, tx_valid, tx_ready, rx_valid, rx_acked;
  logic            rx_msg_done, ack_enable, out_valid, out_show_header, out_rx_error;
  logic            out_prompt;
  logic [ID_W-1:0] tx_id, rx_id;
  logic [23:0]     tx_data;
  logic [7:0]      can_options, can_divisor;
  int              n_mismatch = 0;
  int              check_count = 0;
  int              n_val = 0;
  int              n_err = 0;
  int              n_prompt = 0;
  int              v0, e0, pm;
  int              n_cyc = 0;

  jrm_monitor #(.MS_CYC(10)) i_jrm_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_valid, .tx_ready, .tx_id, .tx_data,
    .rx_valid, .rx_id, .rx_acked, .rx_msg_done, .ack_enable, .can_options, .can_divisor,
    .out_valid, .out_header, .out_show_header, .out_rx_error, .out_prompt);

  jrm_can_model #(.GAP(500)) i_jrm_can_model (.pclk, .presetn, .tx_valid, .tx_id,
    .tx_data, .tx_ready, .rx_valid, .rx_id, .rx_acked, .rx_msg_done);

  initial begin
    forever #5 pclk = ~pclk;
  end

  // Pulse counters of the print stream
  always @(posedge pclk) begin
    if (out_valid === 1'b1) n_val++;
    if (out_rx_error === 1'b1) n_err++;
    if (out_prompt === 1'b1) n_prompt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] code, input logic [31:0] arg);
    apb(1'b1, OFS_ARG, arg);
    apb(1'b1, OFS_CMD, {24'h0, code});
    repeat (2) @(posedge pclk);
  endtask

  task automatic rd_mask(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_data & m, e);
  endtask

  task automatic snap;
    v0 = n_val;
    e0 = n_err;
    pm = n_prompt;
  endtask

  task automatic frame(input logic [ID_W-1:0] id, input logic ack, input logic done);
    i_jrm_can_model.send_frame(id, ack, done);
    repeat (3) @(posedge pclk);
  endtask

  task automatic expect_prompt;
    for (n_cyc = 0; n_cyc < 3000 && n_prompt == pm; n_cyc++) @(posedge pclk);
    chk(32'(n_prompt - pm), 32'd1);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #500000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_mask(OFS_CTRL, 32'h1f, 32'h0e);
    rd_mask(OFS_ID, '1, 32'h18eafff9);
    chk({16'h0, can_options, can_divisor}, 32'h4202);
    chk({31'h0, ack_enable}, 32'h0);
    chk({31'h0, out_show_header}, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    snap;
    cmd(CMD_REQUEST, 32'h0000feee);
    frame(29'h18e8ff00, 1'b1, 1'b1);
    expect_prompt;
    chk({3'h0, i_jrm_can_model.got_id}, 32'h18eafff9);
    chk({8'h0, i_jrm_can_model.got_data}, 32'heefe00);
    chk(32'(n_val - v0), 32'd1);
    rd_mask(OFS_STATUS, 32'h100, 32'h0);
    cmd(CMD_SWAP_OFF, 32'h0);
    i_jrm_can_model.stall = 0;
    snap;
    cmd(CMD_REQUEST, 32'h0000feee);
    expect_prompt;
    chk({8'h0, i_jrm_can_model.got_data}, 32'h00feee);
    rd_mask(OFS_STATUS, 32'h100, 32'h100);
    cmd(CMD_PRIORITY, 32'hf9);
    rd_mask(OFS_ID, '1, 32'h19eafff9);
    cmd(CMD_HEADER3, 32'h00ea00f9);
    rd_mask(OFS_ID, '1, 32'h19ea00f9);
    cmd(CMD_HEADER4, 32'hffffffff);
    rd_mask(OFS_ID, '1, 32'h1fffffff);
    cmd(CMD_TESTER_ADDR, 32'h55);
    rd_mask(OFS_ID, '1, 32'h1fffff55);
    cmd(CMD_PROTOCOL, 32'h0b);
    cmd(CMD_OPTS_DIV, 32'h4204);
    chk({16'h0, can_options, can_divisor}, 32'h4204);
    cmd(CMD_SOFT_RESET, 32'h0);
    chk({16'h0, can_options, can_divisor}, 32'h4201);
    rd_mask(OFS_ID, '1, 32'h18eafff9);
    cmd(CMD_OPTS_DIV, 32'h4203);
    cmd(CMD_STORE_RATE, 32'h4203);
    cmd(CMD_OPTS_DIV, 32'h4204);
    cmd(CMD_SOFT_RESET, 32'h0);
    chk({16'h0, can_options, can_divisor}, 32'h4203);
    cmd(CMD_PROTOCOL, {24'h0, PROTO_A});
    chk({16'h0, can_options, can_divisor}, 32'h4202);
    apb(1'b1, OFS_TMO, 32'h2);
    cmd(CMD_TMO_X5, 32'h0);
    rd_mask(OFS_CTRL, 32'h10, 32'h10);
    snap;
    cmd(CMD_REQUEST, 32'h0000feee);
    expect_prompt;
    chk({31'h0, n_cyc > 80}, 32'h1);
    cmd(CMD_TMO_X1, 32'h0);
    rd_mask(OFS_CTRL, 32'h10, 32'h0);
    snap;
    cmd(CMD_REQUEST, 32'h0000feee);
    expect_prompt;
    chk({31'h0, n_cyc < 40}, 32'h1);
    snap;
    cmd(CMD_DM1, 32'h0);
    frame(29'h18feca00, 1'b0, 1'b0);
    frame(29'h18fecb00, 1'b1, 1'b0);
    chk(32'(n_val - v0), 32'd1);
    chk(32'(n_err - e0), 32'd1);
    cmd(CMD_STOP, 32'h0);
    expect_prompt;
    cmd(CMD_SILENT_OFF, 32'h0);
    chk({31'h0, ack_enable}, 32'h1);
    cmd(CMD_HDR_ON, 32'h0);
    rd_mask(OFS_CTRL, 32'h1, 32'h1);
    chk({31'h0, out_show_header}, 32'h1);
    snap;
    cmd(CMD_GROUP_MON, 32'h0100feca);
    frame(29'h18fecb00, 1'b0, 1'b1);
    frame(29'h18feca00, 1'b0, 1'b1);
    expect_prompt;
    chk(32'(n_err - e0), 32'd0);
    chk(32'(n_val - v0), 32'd1);
    rd_mask(OFS_RXHDR, '1, 32'h60feca00);
    cmd(CMD_HDR_FMT_OFF, 32'h0);
    snap;
    cmd(CMD_GROUP_MON, 32'h1100feca);
    frame(29'h18feca00, 1'b1, 1'b1);
    expect_prompt;
    rd_mask(OFS_RXHDR, '1, 32'h18feca00);
    chk(out_header, 32'h18feca00);
    end_of_test;
  end
endmodule
